// File: fcs_host.sv
// host controller that sequences commands into a parallel nor flash
// Summary of operation
// R01 - flash wakes in array read; plain reads need no command first.
// R02 - flash returns to array read itself after program or erase.
// R03 - in suspend, reads in the erasing sector return status bits.
// R04 - after timeout status bit high, host writes reset before reading array.
// R05 - unlock pair plus id command enters id mode; reset leaves it.
// R06 - normal program is four writes: unlock pair, setup, location and value.
// R07 - flash latches address on later falling, data on earlier rising strobe.
// R08 - flash finishes programming on its own timer.
// R09 - programming only clears bits; only erase sets them.
// R10 - flash raises timeout status bit on overlong program.
// R11 - in bypass, program is two writes until bypass reset.
// R12 - bypass is off after power up.
// R13 - chip erase is six writes ending in chip erase command.
// R14 - embedded erase preprograms itself.
// R15 - flash ignores all commands during chip erase.
// R16 - sector erase is six writes; top three address bits pick the sector.
// R17 - during sector erase only suspend is honoured.
// R18 - suspend only acts during sector erase.
// R19 - flash is suspended within 20 us of the suspend write.
// R20 - in suspend, other sectors read and program normally.
// R21 - id command refused while erase is suspended.
// R22 - resume continues erase; repeat resumes ignored.
// R23 - wrong address, data or order aborts back to array read.
// R24 - unlock is AA at 555 then 55 at 2AA; fixed command bytes.
// R25 - polling status bit inverted while programming, zero while erasing.
// R26 - toggle status bit flips on each read while busy.
// R27 - write only with chip select and write strobe low, output enable high.
// R28 - host polls after program or erase, bounds wait, resets on failure.
module fcs_host
  import fcs_pkg::*;
#(
  parameter logic [31:0] POLL_LIMIT = POLL_LIMIT_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input fcs_op_t cmd,
  input wire logic [18:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic [7:0] dq_i,
  output logic ready,
  output logic done,
  output logic fail,
  output logic [7:0] rdata,
  output logic bypass_on,
  output logic suspended,
  output logic id_mode,
  output fcs_pins_t flash
);
  fcs_state_t state_ff, nxt_state;
  fcs_op_t op_ff, nxt_op;
  logic [18:0] uaddr_ff, nxt_uaddr;
  logic [7:0] udata_ff, nxt_udata;
  logic [2:0] step_ff, nxt_step;
  logic [TCNT_W-1:0] tcnt_ff, nxt_tcnt;
  logic [31:0] pcnt_ff, nxt_pcnt;
  logic polling_ff, nxt_polling, first_ff, nxt_first, recheck_ff, nxt_recheck;
  logic prev_tog_ff, nxt_prev_tog, failing_ff, nxt_failing;
  logic nxt_done, nxt_fail, nxt_byp, nxt_susp, nxt_id;
  logic [7:0] nxt_rdata;
  fcs_word_t cur_word;
  wire tim_done = (tcnt_ff == '0);
  wire take = req && ready;
  wire last_step = (step_ff + 3'h1) == seq_len(op_ff, bypass_on);
  wire tog_now = rdata[TOGGLE_BIT];
  wire poll_over = pcnt_ff >= POLL_LIMIT;

  function automatic logic [2:0] seq_len(fcs_op_t op, logic byp);
    case (op)
      OP_PROG: seq_len = byp ? 3'h2 : 3'h4; // [R06] [R11]
      OP_CHIP, OP_SECT: seq_len = 3'h6; // [R13] [R16]
      OP_ID, OP_BYP_ON: seq_len = 3'h3; // [R05]
      OP_BYP_OFF: seq_len = 3'h2;
      default: seq_len = 3'h1;
    endcase
  endfunction

  function automatic fcs_word_t step_of(fcs_op_t op, logic [2:0] idx, logic [18:0] a,
                                        logic [7:0] d, logic byp);
    fcs_word_t w;
    case (idx)
      3'h1, 3'h4: w = '{ADDR_UNLOCK2, DATA_UNLOCK2}; // [R24]
      default: w = '{ADDR_UNLOCK1, DATA_UNLOCK1}; // [R24]
    endcase
    case (op)
      OP_PROG: begin
        if (byp) w = (idx == 3'h0) ? {ADDR_ANY, DATA_PROG} : {a, d}; // [R11]
        else if (idx == 3'h2) w.data = DATA_PROG;
        else if (idx == 3'h3) w = '{a, d}; // [R06]
      end
      OP_CHIP, OP_SECT: begin
        if (idx == 3'h2) w.data = DATA_ERASE_SETUP;
        if (idx == 3'h5) begin
          w = (op == OP_CHIP) ? {ADDR_UNLOCK1, DATA_CHIP} : {a, DATA_SECT}; // [R13] [R16]
        end
      end
      OP_ID: if (idx == 3'h2) w.data = DATA_ID; // [R05]
      OP_BYP_ON: if (idx == 3'h2) w.data = DATA_BYP_ON;
      OP_BYP_OFF: w = '{ADDR_ANY, (idx == 3'h0) ? DATA_ID : DATA_BYP_OFF2};
      OP_SUSP: w = '{ADDR_ANY, DATA_SUSP};
      OP_RESUME: w = '{ADDR_ANY, DATA_RESUME};
      default: w = '{ADDR_ANY, DATA_RESET};
    endcase
    return w;
  endfunction

  assign cur_word = step_of(nxt_op, nxt_step, nxt_uaddr, nxt_udata, nxt_byp);

  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_uaddr = uaddr_ff;
    nxt_udata = udata_ff;
    nxt_step = step_ff;
    nxt_tcnt = tim_done ? tcnt_ff : tcnt_ff - 1'b1;
    nxt_pcnt = polling_ff ? pcnt_ff + 32'h1 : 32'h0;
    nxt_polling = polling_ff;
    nxt_first = first_ff;
    nxt_recheck = recheck_ff;
    nxt_prev_tog = prev_tog_ff;
    nxt_failing = failing_ff;
    nxt_done = 1'b0;
    nxt_fail = 1'b0;
    nxt_byp = bypass_on;
    nxt_susp = suspended;
    nxt_id = id_mode;
    nxt_rdata = rdata;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_op = cmd;
          nxt_uaddr = cmd_addr;
          nxt_udata = cmd_data;
          nxt_step = 3'h0;
          if (cmd == OP_ID && suspended) begin
            nxt_done = 1'b1; // [R21]
            nxt_fail = 1'b1;
          end else if (cmd == OP_READ) begin
            nxt_state = ST_RLOW;
            nxt_tcnt = TCNT_W'(ACC_CYC - 1);
          end else begin
            nxt_state = ST_WLOW;
            nxt_tcnt = TCNT_W'(WP_CYC - 1);
          end
        end
      end
      ST_WLOW: if (tim_done) begin
        nxt_state = ST_WHIGH;
        nxt_tcnt = TCNT_W'(WPH_CYC - 1);
      end
      ST_WHIGH: if (tim_done) begin
        if (!last_step) begin
          nxt_step = step_ff + 3'h1;
          nxt_state = ST_WLOW;
          nxt_tcnt = TCNT_W'(WP_CYC - 1);
        end else if (op_ff == OP_PROG || op_ff == OP_CHIP || op_ff == OP_SECT ||
                     op_ff == OP_RESUME) begin
          // erase resume falls back into sector erase polling
          if (op_ff == OP_RESUME) begin
            nxt_op = OP_SECT; // [R22]
            nxt_susp = 1'b0;
          end
          nxt_polling = 1'b1; // [R28]
          nxt_first = 1'b1;
          nxt_recheck = 1'b0;
          nxt_state = ST_RLOW;
          nxt_tcnt = TCNT_W'(ACC_CYC - 1);
        end else if (op_ff == OP_SUSP) begin
          nxt_state = ST_SUSPW;
          nxt_tcnt = TCNT_W'(SUSP_CYC - 1); // [R19]
        end else if (op_ff == OP_ID) begin
          nxt_id = 1'b1; // [R05]
          nxt_state = ST_RLOW;
          nxt_tcnt = TCNT_W'(ACC_CYC - 1);
        end else begin
          if (op_ff == OP_RESET) nxt_id = 1'b0; // [R05]
          if (op_ff == OP_BYP_ON) nxt_byp = 1'b1; // [R11]
          if (op_ff == OP_BYP_OFF) nxt_byp = 1'b0; // [R11]
          nxt_fail = failing_ff; // [R04]
          nxt_failing = 1'b0;
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_RLOW: if (tim_done) begin
        nxt_rdata = dq_i;
        nxt_state = ST_RHIGH;
        nxt_tcnt = TCNT_W'(RH_CYC - 1);
      end
      ST_RHIGH: if (tim_done) begin
        nxt_tcnt = TCNT_W'(ACC_CYC - 1);
        nxt_prev_tog = tog_now;
        nxt_first = 1'b0;
        if (!polling_ff) begin
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end else if (take && cmd == OP_SUSP && op_ff == OP_SECT) begin
          // suspend is only offered while a sector erase is polled
          nxt_polling = 1'b0; // [R18]
          nxt_op = OP_SUSP;
          nxt_step = 3'h0;
          nxt_state = ST_WLOW;
          nxt_tcnt = TCNT_W'(WP_CYC - 1);
        end else if (!first_ff && tog_now == prev_tog_ff) begin
          nxt_polling = 1'b0;
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end else if (poll_over || (recheck_ff && !first_ff)) begin
          nxt_polling = 1'b0; // [R28]
          nxt_failing = 1'b1; // [R04]
          nxt_op = OP_RESET;
          nxt_step = 3'h0;
          nxt_state = ST_WLOW;
          nxt_tcnt = TCNT_W'(WP_CYC - 1);
        end else begin
          if (!first_ff && rdata[TIMEOUT_BIT]) nxt_recheck = 1'b1; // [R04]
          nxt_state = ST_RLOW;
        end
      end
      ST_SUSPW: if (tim_done) begin
        nxt_susp = 1'b1; // [R19]
        nxt_done = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      op_ff <= OP_READ;
      {uaddr_ff, udata_ff, step_ff, tcnt_ff, pcnt_ff} <= '0;
      {polling_ff, first_ff, recheck_ff, prev_tog_ff, failing_ff} <= '0;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      {uaddr_ff, udata_ff, step_ff, tcnt_ff, pcnt_ff} <=
        {nxt_uaddr, nxt_udata, nxt_step, nxt_tcnt, nxt_pcnt};
      {polling_ff, first_ff, recheck_ff, prev_tog_ff, failing_ff} <=
        {nxt_polling, nxt_first, nxt_recheck, nxt_prev_tog, nxt_failing};
    end
  end

  // pins follow the next state so each strobe leaves a flip-flop with no gate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash <= '{addr: '0, dq_o: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      {ready, done, fail, bypass_on, suspended, id_mode, rdata} <= {1'b1, 5'h00, 8'h00}; // [R12]
    end else begin
      flash.addr <= (nxt_state == ST_WLOW || nxt_state == ST_WHIGH) ? cur_word.addr : nxt_uaddr;
      flash.dq_o <= cur_word.data;
      flash.dq_oe <= (nxt_state == ST_WLOW);
      flash.we_n <= !(nxt_state == ST_WLOW); // [R27]
      flash.oe_n <= !(nxt_state == ST_RLOW); // [R27]
      flash.ce_n <= !(nxt_state == ST_WLOW || nxt_state == ST_RLOW); // [R07]
      // while polling, ready marks only the cycle in which suspend is decoded
      ready <= (nxt_state == ST_IDLE) ||
               (nxt_polling && nxt_op == OP_SECT && nxt_state == ST_RHIGH && nxt_tcnt == '0);
      {done, fail, bypass_on, suspended, id_mode, rdata} <=
        {nxt_done, nxt_fail, nxt_byp, nxt_susp, nxt_id, nxt_rdata};
    end
  end

  logic [2:0] wr_cnt_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wr_cnt_ff <= 3'h0;
    else if (state_ff == ST_IDLE || state_ff == ST_RHIGH) wr_cnt_ff <= 3'h0;
    else if (state_ff == ST_WLOW && tim_done) wr_cnt_ff <= wr_cnt_ff + 3'h1;
  end
  wire seq_end = state_ff == ST_WHIGH && tim_done && last_step;

  a_unlock_first: assert property (@(posedge clk) disable iff (!rst_n) // [R24]
    (state_ff == ST_WLOW && step_ff == 3'h0 && seq_len(op_ff, 1'b0) > 3'h2 &&
     !(op_ff == OP_PROG && bypass_on)) |->
    flash.addr == ADDR_UNLOCK1 && flash.dq_o == DATA_UNLOCK1)
    else $error("first unlock write wrong");
  a_prog_four: assert property (@(posedge clk) disable iff (!rst_n) // [R06]
    (seq_end && op_ff == OP_PROG && !bypass_on) |-> wr_cnt_ff == 3'h4)
    else $error("program did not take four writes");
  a_bypass_two: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    (seq_end && op_ff == OP_PROG && bypass_on) |-> wr_cnt_ff == 3'h2)
    else $error("bypass program did not take two writes");
  a_erase_six: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    (seq_end && (op_ff == OP_CHIP || op_ff == OP_SECT)) |-> wr_cnt_ff == 3'h6)
    else $error("erase did not take six writes");
  a_sector_bits: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
    (state_ff == ST_WLOW && op_ff == OP_SECT && step_ff == 3'h5) |->
    flash.addr[SECT_HI:SECT_LO] == uaddr_ff[SECT_HI:SECT_LO] && flash.dq_o == DATA_SECT)
    else $error("sector erase command malformed");
  a_fail_resets: assert property (@(posedge clk) disable iff (!rst_n) // [R04]
    $rose(failing_ff) |-> ##[0:2] (!flash.we_n && flash.dq_o == DATA_RESET))
    else $error("failure not followed by reset write");
  a_poll_bounded: assert property (@(posedge clk) disable iff (!rst_n) // [R28]
    polling_ff |-> pcnt_ff <= POLL_LIMIT + 32'h100)
    else $error("poll wait not bounded");
  a_id_exit: assert property (@(posedge clk) disable iff (!rst_n) // [R05]
    $fell(id_mode) |-> $past(op_ff) == OP_RESET)
    else $error("id mode left without reset");
  a_write_strobes: assert property (@(posedge clk) disable iff (!rst_n) // [R27]
    !flash.we_n |-> !flash.ce_n && flash.oe_n && flash.dq_oe)
    else $error("write strobe with bad companions");
  a_suspend_window: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
    (ready && polling_ff) |-> (state_ff == ST_RHIGH && tim_done && op_ff == OP_SECT))
    else $error("ready raised outside the suspend window");

  c_prog_done: cover property (@(posedge clk) disable iff (!rst_n)
    op_ff == OP_PROG && done && !fail);
  c_suspended: cover property (@(posedge clk) disable iff (!rst_n) $rose(suspended));
  c_fail_path: cover property (@(posedge clk) disable iff (!rst_n) fail);
  c_id_read: cover property (@(posedge clk) disable iff (!rst_n) id_mode && done);
endmodule

// File: fcs_pkg.sv
// shared constants and types for the flash command sequencer host controller
package fcs_pkg;
  localparam int CLK_NS = 5;
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 30;
  localparam int T_ACC_NS = 70;
  localparam int T_RH_NS = 20;
  localparam int T_SUSP_US = 20;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RH_CYC = (T_RH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUSP_CYC = (T_SUSP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TCNT_W = 12;
  localparam int ADDR_W = 19;
  localparam logic [18:0] ADDR_UNLOCK1 = 19'h00555;
  localparam logic [18:0] ADDR_UNLOCK2 = 19'h002AA;
  localparam logic [18:0] ADDR_ANY = 19'h00000;
  localparam logic [7:0] DATA_UNLOCK1 = 8'hAA;
  localparam logic [7:0] DATA_UNLOCK2 = 8'h55;
  localparam logic [7:0] DATA_PROG = 8'hA0;
  localparam logic [7:0] DATA_ID = 8'h90;
  localparam logic [7:0] DATA_BYP_ON = 8'h20;
  localparam logic [7:0] DATA_BYP_OFF2 = 8'h00;
  localparam logic [7:0] DATA_ERASE_SETUP = 8'h80;
  localparam logic [7:0] DATA_CHIP = 8'h10;
  localparam logic [7:0] DATA_SECT = 8'h30;
  localparam logic [7:0] DATA_SUSP = 8'hB0;
  localparam logic [7:0] DATA_RESUME = 8'h30;
  localparam logic [7:0] DATA_RESET = 8'hF0;
  localparam int POLLING_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int SECT_HI = 18;
  localparam int SECT_LO = 16;
  localparam logic [31:0] POLL_LIMIT_DEF = 32'h17D78400;

  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_PROG = 4'h1, OP_CHIP = 4'h2, OP_SECT = 4'h3,
    OP_SUSP = 4'h4, OP_RESUME = 4'h5, OP_RESET = 4'h6, OP_ID = 4'h7,
    OP_BYP_ON = 4'h8, OP_BYP_OFF = 4'h9
  } fcs_op_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_WLOW = 6'h02, ST_WHIGH = 6'h04,
    ST_RLOW = 6'h08, ST_RHIGH = 6'h10, ST_SUSPW = 6'h20
  } fcs_state_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] data;
  } fcs_word_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
  } fcs_pins_t;
endpackage

// File: fcs_flash_model.sv
// behavioural flash device answering the host controller's pins
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC3, // arbitrary value
  parameter int T_PROG_NS = 500,
  parameter int T_ERASE_NS = 3000
) (
  input fcs_pins_t flash,
  output logic [7:0] dq_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:524287];
  logic [18:0] la, pa;
  logic [7:0] pd, rv = 8'hFF;
  logic [2:0] esec;
  logic byp = 1'h0, idm = 1'h0, susp = 1'h0, tout = 1'h0, bad = 1'h0, tog = 1'h0;
  logic chip = 1'h0, p_on = 1'h0, e_on = 1'h0;
  time p_end, e_end, left;
  int step = 0;
  wire wr = !flash.ce_n && !flash.we_n && flash.oe_n;
  wire rd = !flash.ce_n && !flash.oe_n;
  // released bus never shows the stale byte
  assign dq_i = rd ? rv : ~rv;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  task automatic settle();
    if (p_on && !tout && $time >= p_end) begin
      if (bad) tout = 1'h1;
      else begin
        mem[pa] = mem[pa] & pd;
        p_on = 1'h0;
      end
    end
    if (e_on && !susp && $time >= e_end) begin
      for (int i = 0; i < 524288; i++) if (chip || i[18:16] == esec) begin
        mem[i] = 8'h00; // preprogram first
        mem[i] = 8'hFF;
      end
      e_on = 1'h0;
    end
  endtask
  always @(posedge wr) la = flash.addr;
  always @(negedge wr) begin : take
    logic [7:0] d;
    logic u1, u2;
    d = flash.dq_o;
    u1 = la == 19'h00555 && d == 8'hAA;
    u2 = la == 19'h002AA && d == 8'h55;
    settle();
    if (e_on && !susp) begin
      if (!chip && d == 8'hB0) begin
        susp = 1'h1;
        left = e_end - $time;
      end
    end else if (p_on) begin
      if (tout && d == 8'hF0) begin
        tout = 1'h0;
        p_on = 1'h0;
      end
    end else begin
      case (step)
        0: begin
          step = u1 ? 1 : (byp && d == 8'hA0) ? 3 : (byp && d == 8'h90) ? 7 : 0;
          if (d == 8'hF0) idm = 1'h0;
          if (susp && d == 8'h30) begin
            susp = 1'h0;
            e_end = $time + left;
          end
        end
        1: step = u2 ? 2 : 0;
        2: begin
          if (la == 19'h00555 && d == 8'h90 && !susp) idm = 1'h1;
          if (la == 19'h00555 && d == 8'h20) byp = 1'h1;
          step = la != 19'h00555 ? 0 : d == 8'hA0 ? 3 : (d == 8'h80 && !susp) ? 4 : 0;
        end
        3: begin
          pa = la;
          pd = d;
          bad = (mem[la] & d) != d;
          p_on = 1'h1;
          p_end = $time + T_PROG_NS;
          step = 0;
        end
        4: step = u1 ? 5 : 0;
        5: step = u2 ? 6 : 0;
        6: begin
          chip = la == 19'h00555 && d == 8'h10;
          e_on = chip || d == 8'h30;
          esec = la[18:16];
          e_end = $time + T_ERASE_NS;
          step = 0;
        end
        default: begin
          if (d == 8'h00) byp = 1'h0;
          step = 0;
        end
      endcase
    end
  end
  always @(posedge rd) begin
    settle();
    if (p_on) begin
      tog = ~tog;
      rv = {~pd[7], tog, tout, 5'h00};
    end else if (e_on && (!susp || flash.addr[18:16] == esec)) begin
      tog = tog ^ !susp;
      rv = {susp, tog, 6'h00};
    end else if (idm) rv = flash.addr[0] ? DEV_CODE : MAKER_CODE;
    else rv = mem[flash.addr];
  end
endmodule

// File: fcs_host_test.sv
// self-checking bench for the flash command host controller
module fcs_host_test
  import fcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] DEVID = 8'hC3; // arbitrary value
  logic clk = 1'h0, rst_n = 1'h0, req = 1'h0;
  fcs_op_t cmd = OP_READ;
  logic [18:0] cmd_addr = 19'h00000;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] dq_i, rdata;
  logic ready, done, fail, bypass_on, suspended, id_mode, got_fail;
  fcs_pins_t pins;
  int fails = 0, n_checks = 0, cyc = 0, nwr = 0, w;
  initial forever #2.5 clk = ~clk;
  // short poll limit keeps failure paths quick
  fcs_host #(.POLL_LIMIT(32'h000007D0)) uut (.clk(clk), .rst_n(rst_n), .req(req), .cmd(cmd),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .dq_i(dq_i), .ready(ready), .done(done),
    .fail(fail), .rdata(rdata), .bypass_on(bypass_on), .suspended(suspended),
    .id_mode(id_mode), .flash(pins));
  fcs_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVID)) flash_dev (.flash(pins), .dq_i(dq_i));
  always @(negedge pins.we_n) nwr++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic launch(input fcs_op_t c, input logic [18:0] a, input logic [7:0] d);
    req <= 1'h1;
    cmd <= c;
    cmd_addr <= a;
    cmd_data <= d;
    // hold the order until an edge that samples ready high
    do @(posedge clk); while (ready !== 1'h1);
    req <= 1'h0;
  endtask
  task automatic op(input fcs_op_t c, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    launch(c, a, d);
    while (done !== 1'h1 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    got_fail = fail;
    chk("done", 8'h01, {7'h00, done});
  endtask
  task automatic rd_chk(input logic [18:0] a, input logic [7:0] exp);
    op(OP_READ, a, 8'h00);
    chk("rdata", exp, rdata);
  endtask
  task automatic t_read();
    chk("bypass_on", 8'h00, {7'h00, bypass_on});
    rd_chk(19'h01234, 8'hFF);
  endtask
  task automatic t_prog();
    w = nwr;
    op(OP_PROG, 19'h01234, 8'h5A);
    chk("writes", 8'h04, 8'(nwr - w));
    chk("fail", 8'h00, {7'h00, got_fail});
    rd_chk(19'h01234, 8'h5A);
  endtask
  task automatic t_bad();
    op(OP_PROG, 19'h01234, 8'hA5);
    chk("fail", 8'h01, {7'h00, got_fail});
    rd_chk(19'h01234, 8'h5A);
  endtask
  task automatic t_id();
    op(OP_ID, 19'h00000, 8'h00);
    chk("id_mode", 8'h01, {7'h00, id_mode});
    rd_chk(19'h00001, DEVID);
    rd_chk(19'h00000, MAKER);
    op(OP_RESET, 19'h00000, 8'h00);
    chk("id_mode", 8'h00, {7'h00, id_mode});
    rd_chk(19'h01234, 8'h5A);
  endtask
  task automatic t_byp();
    op(OP_BYP_ON, 19'h00000, 8'h00);
    chk("bypass_on", 8'h01, {7'h00, bypass_on});
    w = nwr;
    op(OP_PROG, 19'h20010, 8'h0F);
    chk("writes", 8'h02, 8'(nwr - w));
    rd_chk(19'h20010, 8'h0F);
    op(OP_BYP_OFF, 19'h00000, 8'h00);
    chk("bypass_on", 8'h00, {7'h00, bypass_on});
    w = nwr;
    op(OP_PROG, 19'h20011, 8'hF0);
    chk("writes", 8'h04, 8'(nwr - w));
    rd_chk(19'h20011, 8'hF0);
  endtask
  task automatic t_sect();
    op(OP_PROG, 19'h30005, 8'h00);
    launch(OP_SECT, 19'h30000, 8'h00);
    repeat (150) @(posedge clk);
    op(OP_SUSP, 19'h00000, 8'h00);
    chk("suspended", 8'h01, {7'h00, suspended});
    op(OP_READ, 19'h30005, 8'h00);
    chk("status", 8'h01, {7'h00, rdata[7]});
    op(OP_PROG, 19'h01235, 8'h11);
    rd_chk(19'h01235, 8'h11);
    op(OP_ID, 19'h00000, 8'h00);
    chk("fail", 8'h01, {7'h00, got_fail});
    chk("id_mode", 8'h00, {7'h00, id_mode});
    op(OP_RESUME, 19'h30000, 8'h00);
    chk("fail", 8'h00, {7'h00, got_fail});
    chk("suspended", 8'h00, {7'h00, suspended});
    rd_chk(19'h30005, 8'hFF);
    rd_chk(19'h01234, 8'h5A);
  endtask
  task automatic t_chip();
    w = nwr;
    op(OP_CHIP, 19'h00000, 8'h00);
    chk("writes", 8'h06, 8'(nwr - w));
    chk("fail", 8'h00, {7'h00, got_fail});
    rd_chk(19'h01234, 8'hFF);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    t_read();
    t_prog();
    t_bad();
    t_id();
    t_byp();
    t_sect();
    t_chip();
    results();
  end
endmodule
